// ---- frs_map.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef FRS_MAP_SVH
`define FRS_MAP_SVH

// register offsets
`define FRS_LOW_CTRL_ADDR 8'hb1
`define FRS_HIGH_CTRL_ADDR 8'hb2
`define FRS_STATUS_ADDR 8'hd2

// reset values
`define FRS_CTRL_RST 8'h00
`define FRS_STATUS_RST 8'h00

// width of one response field and number of monitored faults
`define FRS_FIELD_W 2
`define FRS_NUM_FAULTS 8

// status bit positions
`define FRS_ST_LOW_OUT_OV 0
`define FRS_ST_LOW_OUT_UV 1
`define FRS_ST_LOW_IN_OV 2
`define FRS_ST_LOW_IN_UV 3
`define FRS_ST_HIGH_OUT_OV 4
`define FRS_ST_HIGH_OUT_UV 5
`define FRS_ST_HIGH_IN_OV 6
`define FRS_ST_HIGH_IN_UV 7

// response codes
`define FRS_CODE_FLAG 2'h0
`define FRS_CODE_HICCUP 2'h1
`define FRS_CODE_LATCH 2'h2
`define FRS_CODE_FLAG_ALT 2'h3

// timing
`define FRS_CLK_HZ 10000000
`define FRS_TICK_MS 1
`define FRS_CYC_PER_TICK (`FRS_CLK_HZ / 1000 * `FRS_TICK_MS)
`define FRS_HICCUP_MS 500
`define FRS_HICCUP_TICKS (`FRS_HICCUP_MS / `FRS_TICK_MS)
`define FRS_TICK_CNT_W 14
`define FRS_HICCUP_CNT_W 9

`endif

// ---- frs_pkg.sv ----
// types shared by the fault response selection block
`include "frs_map.svh"

package frs_pkg;

  typedef enum logic [1:0] {
    CELL_IDLE,
    CELL_HICCUP,
    CELL_LATCHED
  } frs_cell_state_t;

  typedef struct packed {
    frs_cell_state_t state;
    logic [`FRS_HICCUP_CNT_W-1:0] cnt;
  } frs_cell_t;

  typedef struct packed {
    logic [`FRS_TICK_CNT_W-1:0] cnt;
    logic tick;
  } frs_div_t;

  typedef struct packed {
    logic [7:0] low_ctrl;
    logic [7:0] high_ctrl;
    logic [7:0] status;
    logic [7:0] rdata;
    logic alert_n;
    logic stop;
    logic [`FRS_NUM_FAULTS-1:0] cause;
    logic [`FRS_NUM_FAULTS-1:0] latched;
    logic pwm_en_d;
    logic en_d;
  } frs_top_t;

endpackage : frs_pkg

// ---- frs_tick_div.sv ----
// divider giving a one-cycle enable pulse per millisecond
`timescale 1ns/1ns
`default_nettype none
`include "frs_map.svh"

module frs_tick_div #(
  parameter int TICK_CYCLES = `FRS_CYC_PER_TICK
) (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset, high
  output logic tick // one-cycle enable pulse
);

  localparam logic [`FRS_TICK_CNT_W-1:0] LAST =
    `FRS_TICK_CNT_W'(TICK_CYCLES - 1);

  frs_pkg::frs_div_t s_reg;
  frs_pkg::frs_div_t s_next;

  // count up through the period and pulse at its end
  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (s_reg.cnt == LAST) begin
      s_next.cnt = '0;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick = s_reg.tick;

endmodule : frs_tick_div
`default_nettype wire

// ---- frs_resp_cell.sv ----
// response sequencer for one monitored fault
`timescale 1ns/1ns
`default_nettype none
`include "frs_map.svh"

module frs_resp_cell #(
  parameter int HICCUP_TICKS = `FRS_HICCUP_TICKS
) (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset, high
  input wire logic fault, // comparator says fault present
  input wire logic [1:0] code, // effective response code
  input wire logic tick, // millisecond enable
  input wire logic recover, // enable toggled by outside party
  output logic stop, // this fault holds switching off
  output logic latched // this fault is latched off
);

  localparam logic [`FRS_HICCUP_CNT_W-1:0] RELOAD =
    `FRS_HICCUP_CNT_W'(HICCUP_TICKS);

  frs_pkg::frs_cell_t s_reg;
  frs_pkg::frs_cell_t s_next;

  // choose response on a fault and run the restart delay
  always_comb begin
    s_next = s_reg;
    case (s_reg.state)
      frs_pkg::CELL_IDLE: begin
        if (fault && code == `FRS_CODE_HICCUP) begin
          s_next.state = frs_pkg::CELL_HICCUP;
          s_next.cnt = RELOAD;
        end else if (fault && code == `FRS_CODE_LATCH) begin
          s_next.state = frs_pkg::CELL_LATCHED;
        end
      end
      frs_pkg::CELL_HICCUP: begin
        if (fault) begin
          s_next.cnt = RELOAD;
        end else if (tick) begin
          // last tick of the delay: count is one or zero
          if (s_reg.cnt[`FRS_HICCUP_CNT_W-1:1] == '0) begin
            s_next.state = frs_pkg::CELL_IDLE;
          end else begin
            s_next.cnt = s_reg.cnt - 1'b1;
          end
        end
      end
      frs_pkg::CELL_LATCHED: begin
        if (recover) begin
          s_next.state = frs_pkg::CELL_IDLE;
        end
      end
      default: begin
        s_next.state = frs_pkg::CELL_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '{state: frs_pkg::CELL_IDLE, cnt: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign stop = (s_reg.state != frs_pkg::CELL_IDLE);
  assign latched = (s_reg.state == frs_pkg::CELL_LATCHED);

endmodule : frs_resp_cell
`default_nettype wire

// ---- frs_fault_resp.sv ----
// per-fault response selection for bus over and undervoltage events
`timescale 1ns/1ns
`default_nettype none
`include "frs_map.svh"

////////////////////////////////////////////////////////////////////////
// Operation
// - with the individual enable high each fault uses its own field.
// - with the individual enable low the strapped mode code is used.
// - code 00 sets the status bit and pulls alert low, no stop.
// - code 01 stops switching and restarts 500 ms after the fault goes.
// - code 10 stops switching until an enable input is toggled.
// - code 11 acts exactly like code 00.
// - low bus input overvoltage uses bits 5:4 of low_bus_fault_response_ctrl, status bit 2.
// - low bus input undervoltage uses bits 7:6 of low_bus_fault_response_ctrl, status bit 3.
// - high bus output overvoltage uses bits 1:0 of high_bus_fault_response_ctrl, status bit 4.
// - high_bus_fault_response_ctrl is a protectable read/write byte resetting to 00h.
// - every field resets to 00 so with the individual enable high all faults start as flag only.
// - low_bus_fault_response_ctrl bits 1:0 and 3:2 serve low bus output OV and UV, bits 0,1.
// - high bus output undervoltage uses bits 3:2 of high_bus_fault_response_ctrl, status bit 5.
// - high bus input overvoltage uses bits 5:4 of high_bus_fault_response_ctrl, status bit 6.
// - high bus input undervoltage uses bits 7:6 of high_bus_fault_response_ctrl, status bit 7.
module frs_fault_resp #(
  parameter int TICK_CYCLES = `FRS_CYC_PER_TICK,
  parameter int HICCUP_TICKS = `FRS_HICCUP_TICKS
) (
  input wire logic REF_CLK, // system clock, 10 MHz
  input wire logic SYS_RST, // synchronous reset, high
  input wire logic REG_WR, // register write strobe
  input wire logic [7:0] REG_ADDR, // register address
  input wire logic [7:0] REG_WDATA, // register write data
  input wire logic WR_PROTECT, // blocks control register writes
  input wire logic IND_RESP_EN, // individual response enable
  input wire logic [1:0] PIN_MODE, // strapped response code
  input wire logic [7:0] FAULT_IN, // comparator faults, status order
  input wire logic PWM_EN, // switching enable from outside
  input wire logic EN, // chip enable from outside
  output logic [7:0] REG_RDATA, // read data, one cycle after address
  output logic [7:0] STATUS, // sticky fault status
  output logic FAULT_ALERT_N, // alert, low while status nonzero
  output logic PWM_STOP, // stop switching request
  output logic [7:0] STOP_CAUSE, // faults holding switching off
  output logic [7:0] LATCHED // faults latched off
);

  ////////////////////////////////////////////////////////////////////
  // state and wires

  frs_pkg::frs_top_t s_reg;
  frs_pkg::frs_top_t s_next;

  logic tick;
  logic recover;
  logic [15:0] fields;
  logic [`FRS_NUM_FAULTS-1:0] cell_stop;
  logic [`FRS_NUM_FAULTS-1:0] cell_latched;
  logic [`FRS_NUM_FAULTS*2-1:0] eff_code;
  logic wr_low;
  logic wr_high;
  logic wr_status;

  ////////////////////////////////////////////////////////////////////
  // millisecond enable for the restart delay

  frs_tick_div #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_div (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////
  // field mapping: fault i uses bits 2i+1:2i of {high, low}

  // bits 1:0 and 3:2 of low_bus_fault_response_ctrl feed status bits 0 and 1
  // bits 5:4 and 7:6 of low_bus_fault_response_ctrl feed status bits 2 and 3
  // bits 1:0 .. 7:6 of high_bus_fault_response_ctrl feed status bits 4 .. 7
  assign fields = {s_reg.high_ctrl, s_reg.low_ctrl};

  // a falling enable input releases latched faults
  assign recover = (s_reg.pwm_en_d & ~PWM_EN) |
                   (s_reg.en_d & ~EN);

  ////////////////////////////////////////////////////////////////////
  // one response cell per fault

  genvar gi;
  generate
    for (gi = 0; gi < `FRS_NUM_FAULTS; gi++) begin : g_fault
      // strapped mode overrides the field when individual enable is low
      assign eff_code[gi*2 +: 2] = IND_RESP_EN ?
        fields[gi*2 +: 2] : PIN_MODE;

      frs_resp_cell #(
        .HICCUP_TICKS(HICCUP_TICKS)
      ) u_cell (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .fault(FAULT_IN[gi]),
        .code(eff_code[gi*2 +: 2]),
        .tick(tick),
        .recover(recover),
        .stop(cell_stop[gi]),
        .latched(cell_latched[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // register write decode

  // control writes are refused while protection is on
  assign wr_low = REG_WR && !WR_PROTECT &&
                  REG_ADDR == `FRS_LOW_CTRL_ADDR;
  assign wr_high = REG_WR && !WR_PROTECT &&
                   REG_ADDR == `FRS_HIGH_CTRL_ADDR;
  // status clear is a write of ones, not blocked by protection
  assign wr_status = REG_WR && REG_ADDR == `FRS_STATUS_ADDR;

  ////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_next = s_reg;

    // control registers
    if (wr_low) begin
      s_next.low_ctrl = REG_WDATA;
    end
    if (wr_high) begin
      s_next.high_ctrl = REG_WDATA;
    end

    // sticky status: clear by writing ones, a new fault wins
    if (wr_status) begin
      s_next.status = s_reg.status & ~REG_WDATA;
    end
    // every code sets its status bit on a fault
    s_next.status = s_next.status | FAULT_IN;

    // alert follows the status register
    s_next.alert_n = ~|s_next.status;

    // switching stops only for hiccup or latched cells
    s_next.stop = |cell_stop;
    s_next.cause = cell_stop;
    s_next.latched = cell_latched;

    // enable history for toggle detection
    s_next.pwm_en_d = PWM_EN;
    s_next.en_d = EN;

    // registered readback
    case (REG_ADDR)
      `FRS_LOW_CTRL_ADDR: begin
        s_next.rdata = s_reg.low_ctrl;
      end
      `FRS_HIGH_CTRL_ADDR: begin
        s_next.rdata = s_reg.high_ctrl;
      end
      `FRS_STATUS_ADDR: begin
        s_next.rdata = s_reg.status;
      end
      default: begin
        s_next.rdata = 8'h00;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // state register

  // fields come out of reset as flag only
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      s_reg <= '0;
      s_reg.low_ctrl <= `FRS_CTRL_RST;
      s_reg.high_ctrl <= `FRS_CTRL_RST;
      s_reg.status <= `FRS_STATUS_RST;
      s_reg.alert_n <= 1'b1;
      s_reg.pwm_en_d <= 1'b0;
      s_reg.en_d <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops

  assign REG_RDATA = s_reg.rdata;
  assign STATUS = s_reg.status;
  assign FAULT_ALERT_N = s_reg.alert_n;
  assign PWM_STOP = s_reg.stop;
  assign STOP_CAUSE = s_reg.cause;
  assign LATCHED = s_reg.latched;

endmodule : frs_fault_resp
`default_nettype wire

// ---- frs_fault_resp_chk.sv ----
// port assertions for the fault response block
`timescale 1ns/1ns
`default_nettype none

module frs_fault_resp_chk #(
  parameter int TICK_CYCLES = 4,
  parameter int HICCUP_TICKS = 3
) (
  input wire logic REF_CLK, // system clock
  input wire logic SYS_RST, // synchronous reset, high
  input wire logic IND_RESP_EN, // individual response enable
  input wire logic [1:0] PIN_MODE, // strapped response code
  input wire logic [7:0] FAULT_IN, // comparator faults
  input wire logic PWM_EN, // switching enable
  input wire logic EN, // chip enable
  input wire logic [7:0] STATUS, // sticky status
  input wire logic FAULT_ALERT_N, // alert, low active
  input wire logic PWM_STOP, // stop request
  input wire logic [7:0] STOP_CAUSE, // stop per fault
  input wire logic [7:0] LATCHED // latch-off per fault
);
  localparam int HMAX = HICCUP_TICKS * TICK_CYCLES + 2;
  localparam int HMIN = (HICCUP_TICKS - 1) * TICK_CYCLES;
  logic [1:0] up_reg;
  logic [7:0] hc_reg;
  logic ok;
  ////////////////////////////////////////////////////////////
  // edges since reset, and length of a fault-free hiccup stop
  always_ff @(posedge REF_CLK) begin
    up_reg <= SYS_RST ? 2'h0 : up_reg + {1'b0, ~&up_reg};
    hc_reg <= (PWM_STOP && FAULT_IN == 8'h00 && LATCHED == 8'h00) ?
      hc_reg + 8'h01 : 8'h00;
  end
  assign ok = &up_reg;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  ////////////////////////////////////////////////////////////
  alert_level_a:
    assert property (FAULT_ALERT_N == (STATUS == 8'h00))
    else $error("alert does not follow status");
  status_set_a:
    assert property (ok |-> (STATUS & $past(FAULT_IN)) == $past(FAULT_IN))
    else $error("status bit not set by fault");
  stop_any_a:
    assert property (PWM_STOP == (STOP_CAUSE != 8'h00))
    else $error("stop request disagrees with causes");
  pin_hiccup_a:
    assert property (ok && $past(!IND_RESP_EN && PIN_MODE == 2'h1, 2)
      |-> (STOP_CAUSE & ~LATCHED & $past(FAULT_IN, 2) & ~$past(STOP_CAUSE))
      == ($past(FAULT_IN, 2) & ~$past(STOP_CAUSE)))
    else $error("hiccup not entered");
  pin_latch_a:
    assert property (ok && $past(!IND_RESP_EN && PIN_MODE == 2'h2, 2)
      |-> (LATCHED & $past(FAULT_IN, 2) & ~$past(STOP_CAUSE))
      == ($past(FAULT_IN, 2) & ~$past(STOP_CAUSE)))
    else $error("latch-off not entered");
  latch_hold_a:
    assert property (ok && !($past(PWM_EN, 3) && !$past(PWM_EN, 2))
      && !($past(EN, 3) && !$past(EN, 2))
      |-> (LATCHED & $past(LATCHED)) == $past(LATCHED))
    else $error("latch-off left without enable toggle");
  latch_release_a:
    assert property (ok && $past(FAULT_IN, 2) == 8'h00
      && ($past(PWM_EN, 3) && !$past(PWM_EN, 2)
      || $past(EN, 3) && !$past(EN, 2)) |-> LATCHED == 8'h00)
    else $error("latch-off kept after enable toggle");
  hiccup_max_a:
    assert property (hc_reg <= HMAX)
    else $error("hiccup restart too late");
  hiccup_min_a:
    assert property (ok && $fell(PWM_STOP) && $past(LATCHED) == 8'h00
      |-> hc_reg >= HMIN)
    else $error("hiccup restart too early");
endmodule : frs_fault_resp_chk

`default_nettype wire

// ---- frs_plant_model.sv ----
// behavioural comparators and switching enable source
`timescale 1ns/1ns
`default_nettype none

module frs_plant_model (
  input wire logic clk, // system clock
  input wire logic [7:0] trip, // faults asked for by the bench
  input wire logic kick, // ask for one low cycle of the enable
  output logic [7:0] fault_out, // comparator fault levels
  output logic pwm_en_out // switching enable
);
  ////////////////////////////////////////////////////////////
  // quiet comparators, switching enabled at start
  initial begin
    fault_out = 8'h00;
    pwm_en_out = 1'b1;
  end
  // outputs move a short delay after the edge
  always @(posedge clk) begin
    fault_out <= #5 trip;
    pwm_en_out <= #5 ~kick;
  end
endmodule : frs_plant_model

`default_nettype wire

// ---- frs_fault_resp_tb.sv ----
// self-checking bench for the fault response block
`timescale 1ns/1ns
`default_nettype none

module frs_fault_resp_tb;
  localparam int TC = 4;
  localparam int HT = 3;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, prot = 1'b0;
  logic ind = 1'b1, en = 1'b1, kick = 1'b0;
  logic [1:0] pmode = 2'h0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, trip = 8'h00;
  logic [7:0] fault, rdata, status, cause, latched;
  logic alert_n, stop, pwm_en;
  int fail_count = 0;
  int num_checks = 0;
  ////////////////////////////////////////////////////////////
  always #50 clk = ~clk;
  frs_plant_model frs_plant_model_i (.clk(clk), .trip(trip),
    .kick(kick), .fault_out(fault), .pwm_en_out(pwm_en));
  frs_fault_resp #(.TICK_CYCLES(TC), .HICCUP_TICKS(HT))
    frs_fault_resp_i (.REF_CLK(clk), .SYS_RST(rst), .REG_WR(wr),
    .REG_ADDR(addr), .REG_WDATA(wdata), .WR_PROTECT(prot),
    .IND_RESP_EN(ind), .PIN_MODE(pmode), .FAULT_IN(fault),
    .PWM_EN(pwm_en), .EN(en), .REG_RDATA(rdata), .STATUS(status),
    .FAULT_ALERT_N(alert_n), .PWM_STOP(stop), .STOP_CAUSE(cause),
    .LATCHED(latched));
  ////////////////////////////////////////////////////////////
  task automatic print_verdict;
    if (fail_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask : step
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
    step(1);
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    step(1);
    chk(rdata, exp);
  endtask : rreg
  // reset values, protection and an unmapped address
  task automatic t_regs;
    rreg(8'hb1, 8'h00);
    rreg(8'hb2, 8'h00);
    wreg(8'hb1, 8'ha5);
    rreg(8'hb1, 8'ha5);
    wreg(8'hb2, 8'h3c);
    prot = 1'b1;
    wreg(8'hb2, 8'hff);
    prot = 1'b0;
    rreg(8'hb2, 8'h3c);
    wreg(8'h40, 8'h77);
    rreg(8'h40, 8'h00);
  endtask : t_regs
  // one fault response: iv high uses fields, low uses strapped mode
  task automatic t_code(input int i, input logic [1:0] code,
    input logic iv);
    logic [15:0] f;
    logic [7:0] b, hit;
    int n;
    b = 8'h01 << i;
    f = iv ? 16'(code) << (2 * i) : 16'haaaa;
    ind = iv;
    pmode = iv ? ~code : code;
    wreg(8'hb1, f[7:0]);
    wreg(8'hb2, f[15:8]);
    hit = (code == 2'h1 || code == 2'h2) ? b : 8'h00;
    trip = iv ? 8'hff : b;
    step(3);
    chk(status, trip);
    chk({7'h0, alert_n}, 8'h00);
    chk(cause, hit);
    chk({7'h0, stop}, {7'h0, |hit});
    chk(latched, code == 2'h2 ? hit : 8'h00);
    wreg(8'hd2, 8'hff);
    chk(status, trip);
    trip = 8'h00;
    // let the comparators go quiet before the last status clear
    step(2);
    if (code == 2'h2) begin
      step(30);
      chk(latched, hit);
      en = i % 2 == 0;
      kick = i % 2 == 0;
      step(1);
      en = 1'b1;
      kick = 1'b0;
      step(3);
    end
    if (code == 2'h1) begin
      step(4);
      trip = b;
      step(1);
      trip = 8'h00;
    end
    n = 0;
    while (stop !== 1'b0) begin
      step(1);
      n++;
      if (n > 40) begin
        fail_count++;
        print_verdict();
      end
    end
    if (code == 2'h1)
      chk({7'h0, n >= (HT - 1) * TC + 1 && n <= HT * TC + 4}, 8'h01);
    wreg(8'hd2, 8'hff);
    chk(status, 8'h00);
    chk({7'h0, alert_n}, 8'h01);
  endtask : t_code
  ////////////////////////////////////////////////////////////
  initial begin
    step(2);
    rst = 1'b0;
    t_regs();
    for (int i = 0; i < 8; i++)
      for (int c = 0; c < 4; c++)
        t_code(i, 2'(c), 1'b1);
    for (int c = 0; c < 4; c++)
      t_code(0, 2'(c), 1'b0);
    print_verdict();
  end
endmodule : frs_fault_resp_tb

bind frs_fault_resp frs_fault_resp_chk #(.TICK_CYCLES(TICK_CYCLES),
  .HICCUP_TICKS(HICCUP_TICKS)) frs_fault_resp_chk_i (.REF_CLK(REF_CLK),
  .SYS_RST(SYS_RST), .IND_RESP_EN(IND_RESP_EN), .PIN_MODE(PIN_MODE),
  .FAULT_IN(FAULT_IN), .PWM_EN(PWM_EN), .EN(EN), .STATUS(STATUS),
  .FAULT_ALERT_N(FAULT_ALERT_N), .PWM_STOP(PWM_STOP),
  .STOP_CAUSE(STOP_CAUSE), .LATCHED(LATCHED));

`default_nettype wire
